//--- rtl/usbhb_pkg.sv
// constants and types shared by the usb hid uart bridge core
// Function
// RULE1: one control endpoint, one config, one hid interface with interrupt in and out
// RULE2: identification report always returns factory vendor and product codes
// RULE3: begin suspend after 3 ms without bus activity, frames counting as activity
// RULE4: configuration attributes advertise no remote wakeup by default
// RULE5: suspended, wakeup enabled, wake pin input: falling edge signals remote wakeup
// RULE6: serial receive pin wakeup is off after reset, enabled by its own control
// RULE7: power-on or hardware reset restores all defaults and latches the store lock
// RULE8: software or bus reset clears state and both fifos, keeps configuration
// RULE9: transmit path is a 512-byte fifo feeding the transmit shifter
// RULE10: transmit report bytes enter the fifo only after the report is validated
// RULE11: next character loads when the shifter is idle or finished
// RULE12: send start bit, data lsb first, optional parity, then stop bits
// RULE13: 5 to 8 data bits with or without parity, or 9 without; parity generated
// RULE14: 9-bit characters get no parity; ninth bit sent only in wide mode
// RULE15: host selects wide mode by the transfer-mode report
// RULE16: wide mode checks parity, framing, overrun and break per character
// RULE17: status report returns latched errors since last read, then clears them
// RULE18: wide transmit takes two host bytes per character, upper bits zero
// RULE19: wide transmit uses bit 0 of second byte as parity or ninth bit
// RULE20: receive shifter from serial input fills a 512-byte receive fifo
// RULE21: receive data goes to the host only on an interrupt-in request
// RULE22: maximum power defaults to 100 mA, changeable by the usb configuration report
// RULE23: normal mode stores only data, error and break flags dropped
// RULE24: wide receive stores data byte then a flags byte per character
// RULE25: 9-bit wide receive puts ninth bit in bit 0, no parity check
// RULE26: character completing into a full receive fifo is dropped and flags overrun
// RULE27: receive input oversampled, start found on falling edge, bits sampled mid-cell
package usbhb_pkg;
  localparam int CLK_KHZ = 40000;
  localparam int SUSP_TIME_US = 3000;
  localparam int SUSP_CYC = SUSP_TIME_US * CLK_KHZ / 1000;
  localparam int SUSP_W = 18;
  localparam int FIFO_AW = 9;
  localparam int FIFO_DEPTH = 512;
  localparam int STAGE_AW = 6;
  localparam int STAGE_DEPTH = 64;
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] BITS_NINE = 4'h9;
  localparam logic [15:0] FACTORY_VID = 16'h1a2b; // arbitrary value
  localparam logic [15:0] FACTORY_PID = 16'h3c4d; // arbitrary value
  localparam logic [7:0] MAXPWR_RST = 8'h32; // 100 mA in 2 mA units
  localparam logic [7:0] ATTR_BASE = 8'h80;
  localparam int ATTR_SELF_BIT = 6;
  localparam int ATTR_RWAKE_BIT = 5;
  localparam logic [7:0] RPT_STATUS = 8'h42;
  localparam logic [7:0] RPT_XFER = 8'h48;
  localparam logic [7:0] RPT_IDENT = 8'h4f;
  localparam logic [7:0] RPT_USBCFG = 8'h4d;
  localparam logic [7:0] RPT_RXWAKE = 8'h4e;
  localparam int FL_NINTH = 0;
  localparam int FL_PAR = 1;
  localparam int FL_FRM = 2;
  localparam int FL_OVR = 3;
  localparam int FL_BRK = 4;
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_FETCH2 = 2'b01, TX_SHIFT = 2'b11} usbhb_tx_type;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b11,
                            RX_PUSH2 = 2'b10} usbhb_rx_type;
endpackage : usbhb_pkg

//--- rtl/usbhb_fifo.sv
// 512-entry byte fifo with show-ahead read data
`timescale 1ns/10ps
module usbhb_fifo import usbhb_pkg::*; (
  input wire logic mclk_in, // clock
  input wire logic clr_in, // synchronous clear
  input wire logic wr_in, // push
  input wire logic [7:0] wdata_in, // push data
  input wire logic rd_in, // pop
  output logic [7:0] rdata_out, // head entry
  output logic empty_out, // no entries
  output logic [FIFO_AW:0] count_out // entries held
);
  logic [7:0] mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [FIFO_AW:0] cnt_q, cnt_d;
  logic do_wr, do_rd;

  always_comb begin
    do_wr = wr_in && (cnt_q != FIFO_AW'(0) + (FIFO_AW+1)'(FIFO_DEPTH));
    do_rd = rd_in && (cnt_q != '0);
    wp_d = do_wr ? wp_q + 1'b1 : wp_q;
    rp_d = do_rd ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + (FIFO_AW+1)'(do_wr) - (FIFO_AW+1)'(do_rd);
  end

  always_ff @(posedge mclk_in) begin
    if (clr_in) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (do_wr && !clr_in) begin
      mem[wp_q] <= wdata_in;
    end
  end

  assign rdata_out = mem[rp_q];
  assign empty_out = (cnt_q == '0);
  assign count_out = cnt_q;
endmodule : usbhb_fifo

//--- rtl/usbhb_core.sv
// usb hid to uart bridge core: report handling, serial framing, suspend and wake
`timescale 1ns/10ps
module usbhb_core import usbhb_pkg::*; #(
  parameter int SUSP_CYCLES = SUSP_CYC
) (
  input wire logic mclk_in, // 40 MHz clock
  input wire logic rst_in, // power-on or hardware reset
  input wire logic sw_reset_in, // software or usb bus reset
  input wire logic usb_activity_in, // any bus activity incl. frame start
  input wire logic [7:0] out_byte_in, // interrupt-out report byte
  input wire logic out_valid_in, // byte strobe
  input wire logic out_commit_in, // report validated
  input wire logic out_abort_in, // report rejected
  output logic out_ready_out, // may accept bytes
  input wire logic in_req_in, // interrupt-in byte request
  output logic [7:0] in_data_out, // receive byte
  output logic in_valid_out, // in_data_out valid
  output logic in_nak_out, // no data for request
  input wire logic rpt_get_in, // get report strobe
  input wire logic rpt_set_in, // set report strobe
  input wire logic [7:0] rpt_id_in, // report id
  input wire logic [7:0] rpt_data_in, // set report payload
  input wire logic [15:0] cfg_vid_in, // new enumerated vendor
  input wire logic [15:0] cfg_pid_in, // new enumerated product
  input wire logic [7:0] cfg_power_in, // new max power
  input wire logic cfg_self_pwr_in, // new self-powered flag
  input wire logic otp_rwake_en_in, // store: remote wakeup enable
  input wire logic otp_glock_in, // store: global lock
  input wire logic [3:0] char_bits_in, // 5..9 data bits
  input wire logic parity_en_in, // parity on
  input wire logic parity_odd_in, // odd parity
  input wire logic two_stop_in, // two stop bits
  input wire logic [15:0] baud_div_in, // clocks per 1/16 bit
  input wire logic rx_in, // serial input
  output logic tx_out, // serial output
  input wire logic ring_wake_n_in, // ring/wake pin level
  input wire logic ring_wake_input_in, // pin configured as input
  output logic [3:0] status_out, // brk,ovr,frm,par snapshot
  output logic status_valid_out, // status_out updated
  output logic [15:0] ident_vid_out, // factory vendor
  output logic [15:0] ident_pid_out, // factory product
  output logic [15:0] enum_vid_out, // enumerated vendor
  output logic [15:0] enum_pid_out, // enumerated product
  output logic [7:0] max_power_out, // max power, 2 mA units
  output logic [7:0] attr_out, // configuration attributes
  output logic wide_mode_out, // wide mode active
  output logic suspend_out, // suspended
  output logic remote_wake_out, // remote wakeup pulse
  output logic otp_locked_out // store write-locked
);
  logic irst;
  assign irst = rst_in | sw_reset_in; // [RULE8]

  // configuration, kept across software reset
  logic wide_q, wide_d, rxw_q, rxw_d, self_q, self_d;
  logic [15:0] evid_q, evid_d, epid_q, epid_d;
  logic [7:0] pwr_q, pwr_d;
  logic set_ok;

  always_comb begin
    set_ok = rpt_set_in;
    wide_d = wide_q;
    rxw_d = rxw_q;
    evid_d = evid_q;
    epid_d = epid_q;
    pwr_d = pwr_q;
    self_d = self_q;
    if (set_ok && rpt_id_in == RPT_XFER) begin
      wide_d = rpt_data_in[0]; // [RULE15]
    end
    if (set_ok && rpt_id_in == RPT_RXWAKE) begin
      rxw_d = rpt_data_in[0]; // [RULE6]
    end
    if (set_ok && rpt_id_in == RPT_USBCFG) begin
      evid_d = cfg_vid_in;
      epid_d = cfg_pid_in;
      pwr_d = cfg_power_in; // [RULE22]
      self_d = cfg_self_pwr_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin // [RULE7]
      wide_q <= 1'b0;
      rxw_q <= 1'b0;
      evid_q <= FACTORY_VID;
      epid_q <= FACTORY_PID;
      pwr_q <= MAXPWR_RST;
      self_q <= 1'b0;
      otp_locked_out <= otp_glock_in;
      attr_out <= ATTR_BASE;
    end else begin
      wide_q <= wide_d;
      rxw_q <= rxw_d;
      evid_q <= evid_d;
      epid_q <= epid_d;
      pwr_q <= pwr_d;
      self_q <= self_d;
      otp_locked_out <= otp_locked_out;
      attr_out <= ATTR_BASE | (8'(self_d) << ATTR_SELF_BIT)
                  | (8'(otp_rwake_en_in) << ATTR_RWAKE_BIT); // [RULE4]
    end
  end

  assign enum_vid_out = evid_q;
  assign enum_pid_out = epid_q;
  assign max_power_out = pwr_q;
  assign wide_mode_out = wide_q;

  // the identification report never follows the enumerated codes
  always_ff @(posedge mclk_in) begin
    ident_vid_out <= FACTORY_VID; // [RULE2]
    ident_pid_out <= FACTORY_PID;
  end

  // fifos
  logic txf_wr, txf_rd, txf_empty, rxf_wr, rxf_rd, rxf_empty;
  logic [7:0] txf_head, rxf_head, rxf_wdata;
  logic [FIFO_AW:0] txf_cnt, rxf_cnt;
  logic [STAGE_AW:0] stg_cnt_q, stg_cnt_d, stg_rd_q, stg_rd_d;
  logic [7:0] stage_mem [STAGE_DEPTH];

  usbhb_fifo u_txf ( // [RULE9]
    .mclk_in(mclk_in), .clr_in(irst), .wr_in(txf_wr), .wdata_in(stage_mem[stg_rd_q[5:0]]),
    .rd_in(txf_rd), .rdata_out(txf_head), .empty_out(txf_empty), .count_out(txf_cnt)
  );
  usbhb_fifo u_rxf ( // [RULE20]
    .mclk_in(mclk_in), .clr_in(irst), .wr_in(rxf_wr), .wdata_in(rxf_wdata),
    .rd_in(rxf_rd), .rdata_out(rxf_head), .empty_out(rxf_empty), .count_out(rxf_cnt)
  );

  // baud tick, 16 per bit
  logic [15:0] div_q, div_d;
  logic tick;
  always_comb begin
    tick = (div_q == 16'h0000);
    // a divider of 0 or 1 ticks every clock
    div_d = (baud_div_in <= 16'h0001 || div_q >= baud_div_in - 16'h0001) ? 16'h0000
            : div_q + 16'h0001;
  end

  // run-time state: suspend, wake, status latches, interrupt-in answers
  logic [SUSP_W-1:0] idle_q, idle_d;
  logic susp_d, wake_d, rw_prev_q, rx_prev_q, st_rd, stv_d, inv_d, nak_d;
  logic [3:0] lat_q, lat_d, ev, sto_d;
  logic [7:0] ind_d;

  always_comb begin
    idle_d = idle_q;
    susp_d = suspend_out;
    if (usb_activity_in) begin
      idle_d = '0;
      susp_d = 1'b0;
    end else if (idle_q == SUSP_W'(SUSP_CYCLES - 1)) begin
      susp_d = 1'b1; // [RULE3]
    end else begin
      idle_d = idle_q + 1'b1;
    end
    wake_d = suspend_out && ((otp_rwake_en_in && ring_wake_input_in && rw_prev_q
             && !ring_wake_n_in) || (rxw_q && rx_prev_q && !rx_in)); // [RULE5] [RULE6]
    st_rd = rpt_get_in && rpt_id_in == RPT_STATUS;
    // a new event in the read cycle is reported and also stays latched
    lat_d = (st_rd ? 4'h0 : lat_q) | ev; // [RULE17]
    sto_d = st_rd ? (lat_q | ev) : status_out;
    stv_d = st_rd;
    rxf_rd = in_req_in && !rxf_empty; // [RULE21]
    inv_d = rxf_rd;
    nak_d = in_req_in && rxf_empty;
    ind_d = rxf_rd ? rxf_head : in_data_out;
  end

  always_ff @(posedge mclk_in) begin
    if (irst) begin
      div_q <= '0;
      idle_q <= '0;
      suspend_out <= 1'b0;
      remote_wake_out <= 1'b0;
      rw_prev_q <= 1'b1;
      rx_prev_q <= 1'b1;
      lat_q <= 4'h0;
      status_out <= 4'h0;
      status_valid_out <= 1'b0;
      in_valid_out <= 1'b0;
      in_nak_out <= 1'b0;
      in_data_out <= 8'h00;
    end else begin
      div_q <= div_d;
      idle_q <= idle_d;
      suspend_out <= susp_d;
      remote_wake_out <= wake_d;
      rw_prev_q <= ring_wake_n_in;
      rx_prev_q <= rx_in;
      lat_q <= lat_d;
      status_out <= sto_d;
      status_valid_out <= stv_d;
      in_valid_out <= inv_d;
      in_nak_out <= nak_d;
      in_data_out <= ind_d;
    end
  end

  // transmit: report staging, then character framing
  logic drain_q, drain_d, stg_wr, rdy_d;
  usbhb_tx_type tx_st_q, tx_st_d;
  logic [11:0] tx_shift_reg_q, tsr_d;
  logic [3:0] tx_ovs_q, tx_ovs_d, tx_left_q, tx_left_d, nb_tx;
  logic [7:0] tx_lo_q, tx_lo_d;
  logic [8:0] td;
  logic tpar, par_tx, load;

  always_comb begin
    stg_cnt_d = stg_cnt_q;
    stg_rd_d = stg_rd_q;
    drain_d = drain_q;
    stg_wr = 1'b0;
    txf_wr = 1'b0;
    if (!drain_q) begin
      stg_wr = out_valid_in && stg_cnt_q != (STAGE_AW+1)'(STAGE_DEPTH);
      stg_cnt_d = stg_cnt_q + (STAGE_AW+1)'(stg_wr);
      if (out_abort_in) begin
        stg_cnt_d = '0;
      end else if (out_commit_in) begin
        drain_d = 1'b1;
      end
    end else if (stg_rd_q == stg_cnt_q) begin
      drain_d = 1'b0;
      stg_cnt_d = '0;
      stg_rd_d = '0;
    end else if (txf_cnt != (FIFO_AW+1)'(FIFO_DEPTH)) begin
      txf_wr = 1'b1; // [RULE10]
      stg_rd_d = stg_rd_q + 1'b1;
    end
    rdy_d = !drain_d && stg_cnt_d != (STAGE_AW+1)'(STAGE_DEPTH); // [RULE1]
    // 9-bit characters lose the ninth bit outside wide mode
    nb_tx = (char_bits_in == BITS_NINE && !wide_q) ? 4'h8 : char_bits_in; // [RULE14]
    par_tx = parity_en_in && char_bits_in != BITS_NINE; // [RULE13]
    tx_st_d = tx_st_q;
    tsr_d = tx_shift_reg_q;
    tx_ovs_d = tx_ovs_q;
    tx_left_d = tx_left_q;
    tx_lo_d = tx_lo_q;
    txf_rd = 1'b0;
    load = 1'b0;
    td = {1'b0, txf_head};
    tpar = parity_odd_in;
    case (tx_st_q)
      TX_IDLE: begin // [RULE11]
        if (!txf_empty) begin
          txf_rd = 1'b1;
          tx_lo_d = txf_head;
          tx_st_d = wide_q ? TX_FETCH2 : TX_SHIFT; // [RULE18]
          load = !wide_q;
        end
      end
      TX_FETCH2: begin
        if (!txf_empty) begin
          txf_rd = 1'b1;
          td = {txf_head[0], tx_lo_q}; // [RULE19]
          tx_st_d = TX_SHIFT;
          load = 1'b1;
        end
      end
      TX_SHIFT: begin
        if (tick) begin
          tx_ovs_d = tx_ovs_q + 1'b1;
          if (tx_ovs_q == OVS_LAST) begin
            tsr_d = {1'b1, tx_shift_reg_q[11:1]};
            tx_left_d = tx_left_q - 1'b1;
            tx_st_d = (tx_left_q == 4'h1) ? TX_IDLE : TX_SHIFT;
          end
        end
      end
      default: tx_st_d = TX_IDLE;
    endcase
    if (load) begin
      tsr_d = 12'hffe; // [RULE12]
      for (int i = 0; i < 9; i++) begin
        if (4'(i) < nb_tx) begin
          tsr_d[i+1] = td[i];
          tpar = tpar ^ td[i];
        end
      end
      if (wide_q) begin
        tpar = td[8];
      end
      for (int j = 5; j < 11; j++) begin
        if (par_tx && 4'(j) == nb_tx + 4'h1) begin
          tsr_d[j] = tpar;
        end
      end
      tx_left_d = 4'h2 + nb_tx + 4'(par_tx) + 4'(two_stop_in);
      tx_ovs_d = 4'h0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (stg_wr) begin
      stage_mem[stg_cnt_q[5:0]] <= out_byte_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (irst) begin
      stg_cnt_q <= '0;
      stg_rd_q <= '0;
      drain_q <= 1'b0;
      out_ready_out <= 1'b0;
      tx_st_q <= TX_IDLE;
      tx_shift_reg_q <= 12'hfff;
      tx_ovs_q <= 4'h0;
      tx_left_q <= 4'h0;
      tx_lo_q <= 8'h00;
    end else begin
      stg_cnt_q <= stg_cnt_d;
      stg_rd_q <= stg_rd_d;
      drain_q <= drain_d;
      out_ready_out <= rdy_d;
      tx_st_q <= tx_st_d;
      tx_shift_reg_q <= tsr_d;
      tx_ovs_q <= tx_ovs_d;
      tx_left_q <= tx_left_d;
      tx_lo_q <= tx_lo_d;
    end
  end
  assign tx_out = tx_shift_reg_q[0];

  // receive: 16x oversampling
  usbhb_rx_type rx_st_q, rx_st_d;
  logic [10:0] rx_shift_reg_q, rsr_d;
  logic [3:0] rx_ovs_q, rx_ovs_d, rx_idx_q, rx_idx_d, rx_tot;
  logic [7:0] rx_fl_q, rx_fl_d, rdat;
  logic povr_q, povr_d, par_rx, perr, done, room, pbit;

  always_comb begin
    par_rx = parity_en_in && char_bits_in != BITS_NINE; // [RULE25]
    rx_tot = char_bits_in + 4'(par_rx);
    rx_st_d = rx_st_q;
    rsr_d = rx_shift_reg_q;
    rx_ovs_d = rx_ovs_q;
    rx_idx_d = rx_idx_q;
    rx_fl_d = rx_fl_q;
    povr_d = povr_q;
    rxf_wr = 1'b0;
    rxf_wdata = 8'h00;
    ev = 4'h0;
    done = 1'b0;
    rdat = 8'h00;
    pbit = parity_odd_in;
    perr = 1'b0;
    room = 1'b0;
    case (rx_st_q)
      RX_IDLE: begin
        if (rx_prev_q && !rx_in) begin // [RULE27]
          rx_st_d = RX_START;
          rx_ovs_d = 4'h0;
        end
      end
      RX_START: begin
        if (tick) begin
          rx_ovs_d = rx_ovs_q + 1'b1;
          if (rx_ovs_q == OVS_MID) begin
            rx_st_d = rx_in ? RX_IDLE : RX_DATA;
            rx_ovs_d = 4'h0;
            rx_idx_d = 4'h0;
          end
        end
      end
      RX_DATA: begin
        if (tick) begin
          rx_ovs_d = rx_ovs_q + 1'b1;
          if (rx_ovs_q == OVS_LAST) begin
            rsr_d[rx_idx_q] = rx_in;
            rx_idx_d = rx_idx_q + 1'b1;
            done = (rx_idx_q == rx_tot);
          end
        end
      end
      RX_PUSH2: begin
        rxf_wr = 1'b1;
        rxf_wdata = rx_fl_q; // [RULE24]
        rx_st_d = RX_IDLE;
      end
      default: rx_st_d = RX_IDLE;
    endcase
    if (done) begin
      for (int k = 0; k < 8; k++) begin
        if (4'(k) < char_bits_in) begin
          rdat[k] = rsr_d[k];
          pbit = pbit ^ rsr_d[k];
        end
      end
      perr = par_rx && (pbit ^ rsr_d[char_bits_in]); // [RULE16]
      rx_fl_d = 8'h00;
      rx_fl_d[FL_NINTH] = (char_bits_in == BITS_NINE) && rsr_d[8];
      rx_fl_d[FL_PAR] = perr;
      rx_fl_d[FL_FRM] = !rx_in;
      rx_fl_d[FL_BRK] = (rsr_d == 11'h000) && !rx_in;
      room = wide_q ? (rxf_cnt < (FIFO_AW+1)'(FIFO_DEPTH - 1))
                    : (rxf_cnt != (FIFO_AW+1)'(FIFO_DEPTH));
      rx_fl_d[FL_OVR] = povr_q;
      ev = {rx_fl_d[FL_BRK], !room, rx_fl_d[FL_FRM], perr};
      rsr_d = 11'h000;
      if (room) begin
        rxf_wr = 1'b1; // [RULE23]
        rxf_wdata = rdat;
        povr_d = 1'b0;
        rx_st_d = wide_q ? RX_PUSH2 : RX_IDLE;
      end else begin
        povr_d = 1'b1; // [RULE26]
        rx_st_d = RX_IDLE;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (irst) begin
      rx_st_q <= RX_IDLE;
      rx_shift_reg_q <= 11'h000;
      rx_ovs_q <= 4'h0;
      rx_idx_q <= 4'h0;
      rx_fl_q <= 8'h00;
      povr_q <= 1'b0;
    end else begin
      rx_st_q <= rx_st_d;
      rx_shift_reg_q <= rsr_d;
      rx_ovs_q <= rx_ovs_d;
      rx_idx_q <= rx_idx_d;
      rx_fl_q <= rx_fl_d;
      povr_q <= povr_d;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  property p_susp; $rose(suspend_out) |-> $past(idle_q) == SUSP_W'(SUSP_CYCLES - 1); endproperty
  a_susp: assert property (p_susp) else $error("suspend without full idle time"); // [RULE3]
  property p_ident; ##1 ident_vid_out == FACTORY_VID && ident_pid_out == FACTORY_PID; endproperty
  a_ident: assert property (p_ident) else $error("identification codes changed"); // [RULE2]
  property p_attr; !otp_rwake_en_in ##1 !otp_rwake_en_in |-> !attr_out[ATTR_RWAKE_BIT]; endproperty
  a_attr: assert property (p_attr) else $error("wakeup advertised while off"); // [RULE4]
  property p_wake; suspend_out && !sw_reset_in && otp_rwake_en_in && ring_wake_input_in
    && $fell(ring_wake_n_in) |=> remote_wake_out; endproperty
  a_wake: assert property (p_wake) else $error("wake pin edge ignored"); // [RULE5]
  property p_rxw; $fell(rst_in) |-> !rxw_q; endproperty
  a_rxw: assert property (p_rxw) else $error("receive wakeup on after reset"); // [RULE6]
  property p_swr; sw_reset_in |=> rxf_empty && txf_empty && wide_q == $past(wide_q); endproperty
  a_swr: assert property (p_swr) else $error("software reset handling wrong"); // [RULE8]
  property p_commit; txf_wr |-> drain_q ##1 !out_ready_out; endproperty
  a_commit: assert property (p_commit) else $error("unvalidated bytes queued"); // [RULE10]
  property p_start; tx_st_q != TX_SHIFT ##1 tx_st_q == TX_SHIFT |-> !tx_out; endproperty
  a_start: assert property (p_start) else $error("frame lacks start bit"); // [RULE12]
  property p_in; in_valid_out || in_nak_out |-> $past(in_req_in); endproperty
  a_in: assert property (p_in) else $error("unrequested interrupt-in data"); // [RULE21]
  property p_ovr; done && !room && !sw_reset_in |=> lat_q[2] && !rxf_wr; endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not recorded"); // [RULE26]
  property p_stclr; st_rd && ev == 4'h0 && !sw_reset_in |=> lat_q == 4'h0 && status_valid_out;
  endproperty
  a_stclr: assert property (p_stclr) else $error("status not cleared on read"); // [RULE17]
  c_wide_rx: cover property (rx_st_q == RX_PUSH2);
  c_tx_done: cover property (tx_st_q == TX_SHIFT ##1 tx_st_q == TX_IDLE);
  c_wake: cover property (remote_wake_out);
endmodule : usbhb_core

//--- test/usbhb_remote.sv
// remote uart model: 8n1 frames at 16 clocks per bit on both serial lines
`timescale 1ns/10ps
module usbhb_remote (
  input wire logic mclk_in, // clock
  input wire logic send_in, // start one frame
  input wire logic [7:0] char_in, // frame data
  output logic line_out, // to core serial input
  input wire logic line_in, // from core serial output
  output logic [7:0] got_out, // last char seen
  output logic rcv_out // pulse per char with good stop bit
);
  logic [9:0] frame;
  initial begin
    line_out = 1'b1;
    rcv_out = 1'b0;
    got_out = 8'h00;
  end
  always begin
    @(posedge send_in);
    frame = {1'b1, char_in, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= frame[i];
      repeat (16) @(posedge mclk_in);
    end
  end
  // sample mid-cell so a clock of skew on the edge is harmless
  always begin
    @(negedge line_in);
    repeat (8) @(posedge mclk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge mclk_in);
      got_out[i] = line_in;
    end
    repeat (16) @(posedge mclk_in);
    rcv_out <= line_in;
    @(posedge mclk_in);
    rcv_out <= 1'b0;
  end
endmodule : usbhb_remote

//--- test/usbhb_core_bench.sv
// self-checking bench for the bridge core against a remote uart model
`timescale 1ns/10ps
module usbhb_core_bench import usbhb_pkg::*;;
  logic mclk_in = 1'b0, rst_in, sw_reset_in, usb_activity_in, out_valid_in, out_commit_in;
  logic out_abort_in, in_req_in, rpt_get_in, rpt_set_in, cfg_self_pwr_in, otp_rwake_en_in;
  logic otp_glock_in, parity_en_in, parity_odd_in, two_stop_in, rx_in, ring_wake_n_in;
  logic ring_wake_input_in, out_ready_out, in_valid_out, in_nak_out, tx_out, status_valid_out;
  logic wide_mode_out, suspend_out, remote_wake_out, otp_locked_out, send, rcv;
  logic [3:0] char_bits_in, status_out;
  logic [7:0] out_byte_in, rpt_id_in, rpt_data_in, cfg_power_in, in_data_out, max_power_out;
  logic [7:0] attr_out, sch, got;
  logic [15:0] cfg_vid_in, cfg_pid_in, baud_div_in, ident_vid_out, ident_pid_out;
  logic [15:0] enum_vid_out, enum_pid_out;
  int fail_count = 0;
  int n_tests = 0;
  always #12.5 mclk_in = ~mclk_in;
  usbhb_core #(.SUSP_CYCLES(50)) dut (.*);
  usbhb_remote peer (.mclk_in(mclk_in), .send_in(send), .char_in(sch), .line_out(rx_in),
    .line_in(tx_out), .got_out(got), .rcv_out(rcv));
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n = 1);
    repeat (n) @(posedge mclk_in);
    #2;
  endtask : tick
  task automatic wait_sig(input string what, ref logic sig, input int lim);
    for (int k = 0; k < lim && sig !== 1'b1; k++) tick();
    if (sig !== 1'b1) begin
      chk(what, 16'h0001, 16'h0000);
      results();
    end
  endtask : wait_sig
  task automatic set_rpt(input logic [7:0] id, input logic [7:0] d);
    rpt_id_in = id;
    rpt_data_in = d;
    rpt_set_in = 1'b1;
    tick();
    rpt_set_in = 1'b0;
    tick();
  endtask : set_rpt
  // nak true expects the empty answer instead of a byte
  task automatic pop(input string what, input logic [7:0] exp, input logic nak);
    in_req_in = 1'b1;
    tick();
    in_req_in = 1'b0;
    if (nak) begin
      wait_sig(what, in_nak_out, 3);
    end else begin
      wait_sig(what, in_valid_out, 3);
      chk(what, {8'h00, exp}, {8'h00, in_data_out});
    end
    tick();
  endtask : pop
  task automatic t_reset;
    chk("max_power", 16'h0032, {8'h00, max_power_out});
    chk("attr", 16'h0080, {8'h00, attr_out});
    chk("enum_pid", FACTORY_PID, enum_pid_out);
    chk("tx idle", 16'h0001, {15'h0000, tx_out});
    cfg_vid_in = 16'h5555;
    cfg_power_in = 8'h64;
    set_rpt(RPT_USBCFG, 8'h00);
    chk("enum_vid", 16'h5555, enum_vid_out);
    chk("ident_vid", FACTORY_VID, ident_vid_out);
    chk("new power", 16'h0064, {8'h00, max_power_out});
    $display("test reset and config done");
  endtask : t_reset
  task automatic t_tx;
    out_byte_in = 8'ha5;
    out_valid_in = 1'b1;
    tick();
    out_valid_in = 1'b0;
    tick(20);
    chk("tx before commit", 16'h0001, {15'h0000, tx_out});
    out_commit_in = 1'b1;
    tick();
    out_commit_in = 1'b0;
    chk("ready while draining", 16'h0000, {15'h0000, out_ready_out});
    wait_sig("tx frame", rcv, 200);
    chk("tx char", 16'h00a5, {8'h00, got});
    $display("test transmit done");
  endtask : t_tx
  task automatic t_rx(input logic w, input logic [7:0] c);
    set_rpt(RPT_XFER, {7'h00, w});
    chk("wide", {15'h0000, w}, {15'h0000, wide_mode_out});
    sch = c;
    send = 1'b1;
    tick();
    send = 1'b0;
    // stop-bit centre lands near 152 clocks after the start edge
    tick(170);
    pop("rx data", c, 1'b0);
    pop("rx flags or empty", 8'h00, !w);
    $display("test receive wide %0d done", w);
  endtask : t_rx
  // 8n1 frame of zeros read with parity on: the stop bit lands in the parity slot
  task automatic t_stat;
    parity_en_in = 1'b1;
    sch = 8'h00;
    send = 1'b1;
    tick();
    send = 1'b0;
    tick(170);
    pop("par data", 8'h00, 1'b0);
    pop("par flags", 8'h02, 1'b0);
    parity_en_in = 1'b0;
    rpt_id_in = RPT_STATUS;
    rpt_get_in = 1'b1;
    tick();
    chk("status", 16'h0011, {11'h000, status_valid_out, status_out});
    tick();
    rpt_get_in = 1'b0;
    chk("status cleared", 16'h0010, {11'h000, status_valid_out, status_out});
    $display("test status done");
  endtask : t_stat
  task automatic t_swr;
    sch = 8'h5a;
    send = 1'b1;
    tick();
    send = 1'b0;
    tick(170);
    sw_reset_in = 1'b1;
    tick();
    sw_reset_in = 1'b0;
    tick();
    pop("fifo after sw reset", 8'h00, 1'b1);
    chk("wide kept", 16'h0001, {15'h0000, wide_mode_out});
    chk("enum kept", 16'h5555, enum_vid_out);
    $display("test soft reset done");
  endtask : t_swr
  task automatic t_susp;
    usb_activity_in = 1'b0;
    tick(40);
    chk("no early suspend", 16'h0000, {15'h0000, suspend_out});
    wait_sig("suspend", suspend_out, 20);
    ring_wake_n_in = 1'b0;
    tick(3);
    chk("wake when disabled", 16'h0000, {15'h0000, remote_wake_out});
    otp_rwake_en_in = 1'b1;
    ring_wake_n_in = 1'b1;
    tick();
    ring_wake_n_in = 1'b0;
    tick();
    chk("wake pulse", 16'h0001, {15'h0000, remote_wake_out});
    chk("attr wake", 16'h00a0, {8'h00, attr_out});
    $display("test suspend done");
  endtask : t_susp
  initial begin
    rst_in = 1'b1;
    {sw_reset_in, out_valid_in, out_commit_in, out_abort_in, in_req_in, send} = '0;
    {rpt_get_in, rpt_set_in, cfg_self_pwr_in, otp_rwake_en_in, otp_glock_in} = '0;
    {parity_en_in, parity_odd_in, two_stop_in} = '0;
    {usb_activity_in, ring_wake_n_in, ring_wake_input_in} = 3'b111;
    {out_byte_in, rpt_id_in, rpt_data_in, cfg_power_in, sch} = '0;
    {cfg_vid_in, cfg_pid_in} = '0;
    char_bits_in = 4'h8;
    baud_div_in = 16'h0001;
    tick(12);
    rst_in = 1'b0;
    tick();
    t_reset();
    t_tx();
    t_rx(1'b0, 8'h3c);
    t_rx(1'b1, 8'h81);
    t_stat();
    t_swr();
    t_susp();
    results();
  end
endmodule : usbhb_core_bench
